// [rtl/phymx_regs.svh]
// Purpose: register offsets, field positions, codes and reset values of the pin mux block
// Assumes: 16-bit registers, each in the low half of one aligned 32-bit bus word
// Notes: printed offsets are register indices; byte address is four times the index
`ifndef PHYMX_REGS_SVH
`define PHYMX_REGS_SVH

// ==========================================================
// register indices and byte addresses
`define PHYMX_IDX_INDICATOR_ONE_PIN_MUX 12'h462
`define PHYMX_IDX_COLLISION_PIN_MUX 12'h463
`define PHYMX_IDX_FIBER_GENERAL_CONFIG 12'h465
`define PHYMX_IDX_STRAP_LATCH_STATUS_ONE 12'h467
`define PHYMX_BYTE_ADDR(idx) ({2'h0, (idx), 2'h0})
`define PHYMX_ADDR_IND_MUX `PHYMX_BYTE_ADDR(`PHYMX_IDX_INDICATOR_ONE_PIN_MUX)
`define PHYMX_ADDR_COL_MUX `PHYMX_BYTE_ADDR(`PHYMX_IDX_COLLISION_PIN_MUX)
`define PHYMX_ADDR_FIBER `PHYMX_BYTE_ADDR(`PHYMX_IDX_FIBER_GENERAL_CONFIG)
`define PHYMX_ADDR_STRAP `PHYMX_BYTE_ADDR(`PHYMX_IDX_STRAP_LATCH_STATUS_ONE)

// ==========================================================
// field positions
`define PHYMX_CTRL_RANGE 2:0
`define PHYMX_SRC_RANGE 6:4
`define PHYMX_POL_BIT 0
`define PHYMX_RSV_RANGE 3:2

// ==========================================================
// reset values
`define PHYMX_CTRL_RST 3'h0
`define PHYMX_FIBER_RST 16'hff00
`define PHYMX_STRAP_STAT_RST 16'h0fc3

// ==========================================================
// pin function codes
`define PHYMX_FN_BASE 3'h0
`define PHYMX_FN_IND 3'h1
`define PHYMX_FN_WOL 3'h2
`define PHYMX_FN_CLK 3'h3
`define PHYMX_FN_PTP_TX 3'h4
`define PHYMX_FN_PTP_RX 3'h5
`define PHYMX_FN_LOW 3'h6
`define PHYMX_FN_HIGH 3'h7

// ==========================================================
// clock source codes, mac modes, mode codes, bus answers
`define PHYMX_CS_MAC_IF 3'h0
`define PHYMX_CS_XTAL 3'h1
`define PHYMX_CS_REF25 3'h2
`define PHYMX_CS_RMII 3'h4
`define PHYMX_CS_FREE 3'h6
`define PHYMX_CS_REC 3'h7
`define PHYMX_MAC_MII 2'h0
`define PHYMX_MAC_RMII 2'h1
`define PHYMX_MAC_RGMII 2'h2
`define PHYMX_MODE1 2'h0
`define PHYMX_MODE4 2'h3
`define PHYMX_RESP_OKAY 2'h0
`define PHYMX_RESP_SLVERR 2'h2
`define PHYMX_SYNC_W 19

`endif

// [rtl/phymx_pkg.sv]
// Purpose: types shared by the pin mux block
// Assumes: constants live in phymx_regs.svh
// Notes: axi field names stay as published
package phymx_pkg;

	// ==========================================================
	// register bus carriers
	typedef struct packed {
		logic [15:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [15:0] araddr;
		logic arvalid;
		logic rready;
	} phymx_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} phymx_axi_rsp_s;

	// ==========================================================
	// straps, clocks, pin functions
	typedef struct packed {
		logic [1:0] rx_d1;
		logic [1:0] rx_d0;
		logic [1:0] col;
		logic [1:0] rx_er;
		logic [1:0] crs;
		logic [1:0] rx_dv;
		logic [1:0] indicator_pin_zero;
		logic [2:0] indicator_pin_one_ctrl;
		logic signal_detect_strap_enable;
	} phymx_strap_s;

	typedef struct packed {
		logic crystal_input_clock;
		logic ref_25m;
		logic ref_50m;
		logic free_125m;
		logic rec_125m;
	} phymx_clk_in_s;

	typedef struct packed {
		logic mac_if;
		logic crystal_input_clock;
		logic ref_25m;
		logic rmii_master;
		logic free_125m;
		logic rec_125m;
	} phymx_clk_sel_s;

	typedef struct packed {
		logic base;
		logic base_drive;
		logic ind;
		logic wol;
		logic ptp_tx;
		logic ptp_rx;
	} phymx_pin_fn_s;

	// ==========================================================
	// block state
	typedef enum logic {STRAP_WAIT, STRAP_RUN} phymx_strap_st_e;

	typedef struct packed {
		phymx_strap_st_e strap_st;
		logic [2:0] ind_ctrl;
		logic [2:0] ind_src;
		logic [2:0] col_ctrl;
		logic [2:0] col_src;
		logic [15:0] fiber_cfg;
		logic [15:0] strap_stat;
		logic sig_det_en;
		logic aw_held;
		logic [15:0] aw_addr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic link_drop;
	} phymx_state_s;

endpackage

// [rtl/phymx_sync.sv]
// Purpose: two-stage synchroniser for slow pin levels
// Assumes: inputs are static or slow compared with i_clock
// Notes: first stage feeds only the second; no reset, so straps settle while reset is held
`timescale 1ns/1ps
`default_nettype none
module phymx_sync #(
	parameter int W = 1
) (
	// clock
	input wire logic i_clock,
	// levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} phymx_sync_s;

	phymx_sync_s q;
	phymx_sync_s n;

	always_comb begin
		n.s1 = i_async;
		n.s2 = q.s1;
	end

	always_ff @(posedge i_clock) begin
		q <= n;
	end

	assign o_sync = q.s2;
endmodule
`default_nettype wire

// [rtl/phymx_pin_sel.sv]
// Purpose: output function and clock source selection for one multifunction pin
// Assumes: control and source codes come from registered fields
// Notes: purely combinational so a field write acts at once
`timescale 1ns/1ps
`default_nettype none
`include "phymx_regs.svh"
module phymx_pin_sel (
	// fields
	input wire logic [2:0] i_ctrl,
	input wire logic [2:0] i_src,
	// sources
	input wire phymx_pkg::phymx_pin_fn_s i_fn,
	input wire phymx_pkg::phymx_clk_sel_s i_clk,
	// pin
	output logic o_pin_out,
	output logic o_pin_oe_n
);
	logic clk_sel;

	always_comb begin
		case (i_src)
			`PHYMX_CS_MAC_IF: clk_sel = i_clk.mac_if;
			`PHYMX_CS_XTAL: clk_sel = i_clk.crystal_input_clock;
			`PHYMX_CS_REF25: clk_sel = i_clk.ref_25m;
			`PHYMX_CS_RMII: clk_sel = i_clk.rmii_master;
			`PHYMX_CS_FREE: clk_sel = i_clk.free_125m;
			`PHYMX_CS_REC: clk_sel = i_clk.rec_125m;
			default: clk_sel = 1'b0; // reserved codes park low
		endcase
	end

	always_comb begin
		o_pin_oe_n = 1'b0;
		case (i_ctrl)
			`PHYMX_FN_BASE: begin
				o_pin_out = i_fn.base;
				o_pin_oe_n = !i_fn.base_drive;
			end
			`PHYMX_FN_IND: o_pin_out = i_fn.ind;
			`PHYMX_FN_WOL: o_pin_out = i_fn.wol;
			`PHYMX_FN_CLK: o_pin_out = clk_sel;
			`PHYMX_FN_PTP_TX: o_pin_out = i_fn.ptp_tx;
			`PHYMX_FN_PTP_RX: o_pin_out = i_fn.ptp_rx;
			`PHYMX_FN_LOW: o_pin_out = 1'b0;
			`PHYMX_FN_HIGH: o_pin_out = 1'b1;
			default: o_pin_out = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// [rtl/phymx_pin_mux_strap.sv]
// Purpose: pin mux control for indicator pin one and collision pin, fiber signal
//   detect polarity and strap readback, behind an axi4-lite slave
// Assumes: function sources come from same-clock logic; straps and pin levels are async
// Notes: straps are captured once, on the first edge after reset release
`timescale 1ns/1ps
`default_nettype none
`include "phymx_regs.svh"
module phymx_pin_mux_strap (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// register bus
	input wire phymx_pkg::phymx_axi_req_s i_axi,
	output var phymx_pkg::phymx_axi_rsp_s o_axi,
	// straps and pin inputs
	input wire phymx_pkg::phymx_strap_s i_strap,
	input wire logic i_indicator_pin_one,
	// clock sources
	input wire phymx_pkg::phymx_clk_in_s i_clk_src,
	input wire logic [1:0] i_mac_mode,
	// function sources
	input wire logic i_speed_100_copper,
	input wire logic i_programmable_activity_indicator,
	input wire logic i_col_normal,
	input wire logic i_wol_ind,
	input wire logic i_ptp_tx_ind,
	input wire logic i_ptp_rx_ind,
	input wire logic i_fiber_100_mode,
	// pins
	output logic o_indicator_pin_one,
	output logic o_indicator_pin_one_oe_n,
	output logic o_col_pin,
	output logic o_col_pin_oe_n,
	// link status
	output logic o_link_drop
);
	// ==========================================================
	// declarations
	phymx_pkg::phymx_state_s q;
	phymx_pkg::phymx_state_s n;
	logic [`PHYMX_SYNC_W-1:0] sync_out;
	phymx_pkg::phymx_strap_s strap_s;
	logic fiber_signal_detect_input;
	logic aw_rdy;
	logic w_rdy;
	logic ar_rdy;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic [16:0] wr_old;
	logic [15:0] wr_val;
	logic [16:0] rd_word;
	phymx_pkg::phymx_clk_sel_s clk_sel;
	phymx_pkg::phymx_pin_fn_s ind_fn;
	phymx_pkg::phymx_pin_fn_s col_fn;
	logic ind_out;
	logic ind_oe_n;

	// ==========================================================
	// helpers
	function automatic logic [16:0] reg_read(input logic [15:0] a,
		input phymx_pkg::phymx_state_s s);
		logic [16:0] r;
		r = 17'h0;
		case (a)
			`PHYMX_ADDR_IND_MUX: r = {1'b1, 9'h0, s.ind_src, 1'b0, s.ind_ctrl};
			`PHYMX_ADDR_COL_MUX: r = {1'b1, 9'h0, s.col_src, 1'b0, s.col_ctrl};
			`PHYMX_ADDR_FIBER: r = {1'b1, s.fiber_cfg};
			`PHYMX_ADDR_STRAP: r = {1'b1, s.strap_stat};
			default: r = 17'h0;
		endcase
		return r;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		logic [15:0] m;
		m[15:8] = strb[1] ? d[15:8] : old[15:8];
		m[7:0] = strb[0] ? d[7:0] : old[7:0];
		return m;
	endfunction

	// ==========================================================
	// pin level synchronisers
	phymx_sync #(
		.W(`PHYMX_SYNC_W)
	) u_sync (
		.i_clock(i_clock),
		.i_async({i_strap, i_indicator_pin_one}),
		.o_sync(sync_out)
	);

	assign strap_s = phymx_pkg::phymx_strap_s'(sync_out[`PHYMX_SYNC_W-1:1]);
	assign fiber_signal_detect_input = sync_out[0];

	// ==========================================================
	// bus handshakes
	assign aw_rdy = !q.aw_held && !q.bvalid;
	assign w_rdy = !q.w_held && !q.bvalid;
	assign ar_rdy = !q.rvalid;
	assign aw_hs = i_axi.awvalid && aw_rdy;
	assign w_hs = i_axi.wvalid && w_rdy;
	assign ar_hs = i_axi.arvalid && ar_rdy;

	always_comb begin
		o_axi.awready = aw_rdy;
		o_axi.wready = w_rdy;
		o_axi.bresp = q.bresp;
		o_axi.bvalid = q.bvalid;
		o_axi.arready = ar_rdy;
		o_axi.rdata = q.rdata;
		o_axi.rresp = q.rresp;
		o_axi.rvalid = q.rvalid;
	end

	// ==========================================================
	// next state
	always_comb begin
		n = q;
		wr_old = reg_read(q.aw_addr, q);
		wr_val = merge16(wr_old[15:0], q.wdata, q.wstrb);
		rd_word = reg_read(i_axi.araddr, q);
		// strap capture on the first cycle after reset release
		case (q.strap_st)
			phymx_pkg::STRAP_WAIT: begin
				n.strap_st = phymx_pkg::STRAP_RUN;
				n.ind_ctrl = strap_s.indicator_pin_one_ctrl;
				n.sig_det_en = strap_s.signal_detect_strap_enable;
				n.strap_stat = {strap_s.rx_d1, strap_s.rx_d0, strap_s.col,
					strap_s.rx_er, strap_s.crs, strap_s.rx_dv, 2'h0,
					(strap_s.indicator_pin_zero == `PHYMX_MODE4) ?
					`PHYMX_MODE4 : `PHYMX_MODE1};
			end
			phymx_pkg::STRAP_RUN: begin
				n.strap_st = phymx_pkg::STRAP_RUN;
			end
			default: begin
				n.strap_st = phymx_pkg::STRAP_WAIT;
			end
		endcase
		// write channel
		if (aw_hs) begin
			n.aw_held = 1'b1;
			n.aw_addr = i_axi.awaddr;
		end
		if (w_hs) begin
			n.w_held = 1'b1;
			n.wdata = i_axi.wdata;
			n.wstrb = i_axi.wstrb;
		end
		if (q.aw_held && q.w_held) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wr_old[16] ? `PHYMX_RESP_OKAY : `PHYMX_RESP_SLVERR;
			case (q.aw_addr)
				`PHYMX_ADDR_IND_MUX: begin
					n.ind_ctrl = wr_val[`PHYMX_CTRL_RANGE];
					n.ind_src = wr_val[`PHYMX_SRC_RANGE];
				end
				`PHYMX_ADDR_COL_MUX: begin
					n.col_ctrl = wr_val[`PHYMX_CTRL_RANGE];
					n.col_src = wr_val[`PHYMX_SRC_RANGE];
				end
				`PHYMX_ADDR_FIBER: n.fiber_cfg = wr_val;
				default: begin
					// strap status is read-only, other addresses unmapped
					n.fiber_cfg = q.fiber_cfg;
				end
			endcase
		end
		if (q.bvalid && i_axi.bready) begin
			n.bvalid = 1'b0;
		end
		// read channel
		if (ar_hs) begin
			n.rvalid = 1'b1;
			n.rdata = {16'h0, rd_word[15:0]};
			n.rresp = rd_word[16] ? `PHYMX_RESP_OKAY : `PHYMX_RESP_SLVERR;
		end else if (q.rvalid && i_axi.rready) begin
			n.rvalid = 1'b0;
		end
		// fiber link drop on the inactive detect level
		n.link_drop = i_fiber_100_mode && q.sig_det_en &&
			(fiber_signal_detect_input == q.fiber_cfg[`PHYMX_POL_BIT]);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			q <= '0;
			q.ind_ctrl <= `PHYMX_CTRL_RST;
			q.fiber_cfg <= `PHYMX_FIBER_RST;
			q.strap_stat <= `PHYMX_STRAP_STAT_RST;
		end else begin
			q <= n;
		end
	end

	assign o_link_drop = q.link_drop;

	// ==========================================================
	// clock sources
	always_comb begin
		clk_sel.mac_if = (i_mac_mode == `PHYMX_MAC_RMII) ?
			i_clk_src.ref_50m : i_clk_src.ref_25m;
		clk_sel.crystal_input_clock = i_clk_src.crystal_input_clock;
		clk_sel.ref_25m = i_clk_src.ref_25m;
		clk_sel.rmii_master = i_clk_src.ref_50m;
		clk_sel.free_125m = i_clk_src.free_125m;
		clk_sel.rec_125m = i_clk_src.rec_125m;
	end

	// ==========================================================
	// pin muxes
	always_comb begin
		ind_fn.base = 1'b0;
		ind_fn.base_drive = 1'b0;
		ind_fn.ind = i_speed_100_copper;
		ind_fn.wol = i_wol_ind;
		ind_fn.ptp_tx = i_ptp_tx_ind;
		ind_fn.ptp_rx = i_ptp_rx_ind;
		col_fn.base = i_col_normal;
		col_fn.base_drive = 1'b1;
		col_fn.ind = i_programmable_activity_indicator;
		col_fn.wol = i_wol_ind;
		col_fn.ptp_tx = i_ptp_tx_ind;
		col_fn.ptp_rx = i_ptp_rx_ind;
	end

	phymx_pin_sel u_ind_sel (
		.i_ctrl(q.ind_ctrl),
		.i_src(q.ind_src),
		.i_fn(ind_fn),
		.i_clk(clk_sel),
		.o_pin_out(ind_out),
		.o_pin_oe_n(ind_oe_n)
	);

	phymx_pin_sel u_col_sel (
		.i_ctrl(q.col_ctrl),
		.i_src(q.col_src),
		.i_fn(col_fn),
		.i_clk(clk_sel),
		.o_pin_out(o_col_pin),
		.o_pin_oe_n(o_col_pin_oe_n)
	);

	// the detect strap turns the pin into an input
	assign o_indicator_pin_one = q.sig_det_en ? 1'b0 : ind_out;
	assign o_indicator_pin_one_oe_n = q.sig_det_en ? 1'b1 : ind_oe_n;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_strap_window;
		q.strap_st == phymx_pkg::STRAP_WAIT;
	endsequence

	sequence s_write_ind_low;
		q.aw_held && q.w_held && (q.aw_addr == `PHYMX_ADDR_IND_MUX) &&
			q.wstrb[0] && (q.wdata[2:0] == `PHYMX_FN_LOW);
	endsequence

	sequence s_write_strap;
		q.aw_held && q.w_held && (q.aw_addr == `PHYMX_ADDR_STRAP);
	endsequence

	a_ind_tristate: assert property (
		(q.ind_ctrl == `PHYMX_FN_BASE) |-> o_indicator_pin_one_oe_n)
		else $error("indicator pin driven in tri-state mode");

	a_ind_const_high: assert property (
		(q.ind_ctrl == `PHYMX_FN_HIGH) && !q.sig_det_en |->
			o_indicator_pin_one && !o_indicator_pin_one_oe_n)
		else $error("indicator pin not high in constant one mode");

	a_strap_load: assert property (
		s_strap_window |=> (q.ind_ctrl == $past(strap_s.indicator_pin_one_ctrl)) &&
			(q.strap_st == phymx_pkg::STRAP_RUN))
		else $error("indicator control not loaded from strap");

	a_ind_clock_src: assert property (
		(q.ind_ctrl == `PHYMX_FN_CLK) && (q.ind_src == `PHYMX_CS_REF25) &&
			!q.sig_det_en |-> o_indicator_pin_one == i_clk_src.ref_25m)
		else $error("indicator pin not carrying the selected clock");

	a_col_normal: assert property (
		(q.col_ctrl == `PHYMX_FN_BASE) |->
			(o_col_pin == i_col_normal) && !o_col_pin_oe_n)
		else $error("collision pin not in normal function");

	a_col_activity: assert property (
		(q.col_ctrl == `PHYMX_FN_IND) |-> o_col_pin == i_programmable_activity_indicator)
		else $error("collision pin not showing activity");

	a_col_reserved_src: assert property (
		(q.col_ctrl == `PHYMX_FN_CLK) && (q.col_src == 3'h5) |-> !o_col_pin)
		else $error("reserved clock source not parked low");

	a_mac_clock_mode: assert property (
		(i_mac_mode == `PHYMX_MAC_RGMII) |-> clk_sel.mac_if == i_clk_src.ref_25m)
		else $error("mac clock source wrong for interface mode");

	a_rmii_master_same: assert property (
		(i_mac_mode == `PHYMX_MAC_RMII) |-> clk_sel.rmii_master == clk_sel.mac_if)
		else $error("rmii master clock differs from mac clock");

	a_fiber_reset: assert property (
		!$past(i_rst_n) |-> (q.fiber_cfg == `PHYMX_FIBER_RST))
		else $error("fiber config reset value wrong");

	a_link_drop: assert property (
		i_fiber_100_mode && q.sig_det_en &&
			(fiber_signal_detect_input == q.fiber_cfg[`PHYMX_POL_BIT]) |=> o_link_drop)
		else $error("link not dropped on inactive detect level");

	a_link_hold: assert property (
		!i_fiber_100_mode |=> !o_link_drop)
		else $error("link drop outside fiber mode");

	a_strap_readonly: assert property (
		s_write_strap ##0 (q.strap_st == phymx_pkg::STRAP_RUN) |=> $stable(q.strap_stat))
		else $error("strap status changed by a write");

	a_strap_rsv_zero: assert property (
		(q.strap_st == phymx_pkg::STRAP_RUN) |-> (q.strap_stat[`PHYMX_RSV_RANGE] == 2'h0))
		else $error("reserved strap bits not zero");

	a_ind0_code: assert property (
		(q.strap_stat[1:0] == `PHYMX_MODE1) || (q.strap_stat[1:0] == `PHYMX_MODE4))
		else $error("indicator zero strap shows reserved code");

	a_strap_read: assert property (
		ar_hs && (i_axi.araddr == `PHYMX_ADDR_STRAP) |=>
			q.rvalid && (q.rdata[15:0] == $past(q.strap_stat)))
		else $error("strap status not returned at its address");

	a_write_effect: assert property (
		s_write_ind_low ##0 !q.sig_det_en |=>
			!o_indicator_pin_one && !o_indicator_pin_one_oe_n)
		else $error("field write did not switch the pin");
endmodule
`default_nettype wire

// [verification/phymx_far_model.sv]
// Purpose: far side of the pin mux, clock sources and fiber transceiver detect line
// Assumes: clock sources are behavioural patterns derived from i_clock
// Notes: every source has its own pattern, so a wrong selection shows within 8 cycles
`timescale 1ns/1ps
`default_nettype none
module phymx_far_model (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// commanded detect level
	input wire logic i_sd_level,
	// towards the block
	output var phymx_pkg::phymx_clk_in_s o_clk,
	output logic o_sd_pin
);
	// ==========================================================
	// clock sources
	logic [2:0] cnt_reg;
	always_ff @(posedge i_clock) begin
		cnt_reg <= i_rst_n ? cnt_reg + 3'h1 : 3'h0;
	end
	assign o_clk = {cnt_reg[0], cnt_reg[1], cnt_reg[2], cnt_reg[0] ^ cnt_reg[2], cnt_reg[1] ^ cnt_reg[2]};
	// ==========================================================
	// transceiver drives its detect output as commanded
	assign o_sd_pin = i_sd_level;
endmodule
`default_nettype wire

// [verification/test_phy_pin_mux_and_strap_readback.sv]
// Purpose: self-checking bench of the pin mux block against a register and pin model
// Assumes: axi master tasks, partner model for clocks and detect line
// Notes: function sources and mac mode change randomly every cycle of each pin check
`timescale 1ns/1ps
`default_nettype none
`include "phymx_regs.svh"
module test_phy_pin_mux_and_strap_readback;
	logic i_clock, i_rst_n, sd_level, spd, programmable_activity_indicator, coln, wol, ptx, prx, fib, sd_pin;
	logic p1, p1_oe_n, pc, pc_oe_n, drop;
	logic [1:0] mac_mode;
	logic [2:0] m_ctrl[2], m_src[2];
	logic [15:0] m_fib;
	int bad_count, samples_checked, seed;
	phymx_pkg::phymx_axi_req_s ax;
	phymx_pkg::phymx_axi_rsp_s rsp;
	phymx_pkg::phymx_strap_s strap;
	phymx_pkg::phymx_clk_in_s clk_src;

	phymx_far_model far (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_sd_level(sd_level),
		.o_clk(clk_src), .o_sd_pin(sd_pin));
	phymx_pin_mux_strap dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_axi(ax), .o_axi(rsp),
		.i_strap(strap), .i_indicator_pin_one(sd_pin), .i_clk_src(clk_src),
		.i_mac_mode(mac_mode), .i_speed_100_copper(spd), .i_programmable_activity_indicator(programmable_activity_indicator),
		.i_col_normal(coln), .i_wol_ind(wol), .i_ptp_tx_ind(ptx), .i_ptp_rx_ind(prx),
		.i_fiber_100_mode(fib), .o_indicator_pin_one(p1), .o_indicator_pin_one_oe_n(p1_oe_n),
		.o_col_pin(pc), .o_col_pin_oe_n(pc_oe_n), .o_link_drop(drop));

	initial begin
		i_clock = 1'h0;
		forever #5 i_clock = ~i_clock;
	end

	// ==========================================================
	// checking
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tmo(input int n);
		if (n >= 50) begin
			bad_count++;
			conclude();
		end
	endtask

	function automatic bit ok(input logic [15:0] a);
		return a inside {`PHYMX_ADDR_IND_MUX, `PHYMX_ADDR_COL_MUX, `PHYMX_ADDR_FIBER, `PHYMX_ADDR_STRAP};
	endfunction

	function automatic logic [31:0] rexp(input logic [15:0] a);
		case (a)
			`PHYMX_ADDR_IND_MUX: return {25'h0, m_src[0], 1'h0, m_ctrl[0]};
			`PHYMX_ADDR_COL_MUX: return {25'h0, m_src[1], 1'h0, m_ctrl[1]};
			`PHYMX_ADDR_FIBER: return {16'h0, m_fib};
			`PHYMX_ADDR_STRAP: return {16'h0, strap.rx_d1, strap.rx_d0, strap.col, strap.rx_er,
				strap.crs, strap.rx_dv, 2'h0, strap.indicator_pin_zero == 2'h3 ? 2'h3 : 2'h0};
			default: return 32'h0;
		endcase
	endfunction

	// returns {oe_n, level}
	function automatic logic [1:0] pexp(input logic [2:0] c, input logic [2:0] s, input bit col);
		logic k;
		case (s)
			3'h0: k = mac_mode == `PHYMX_MAC_RMII ? clk_src.ref_50m : clk_src.ref_25m;
			3'h1: k = clk_src.crystal_input_clock;
			3'h2: k = clk_src.ref_25m;
			3'h4: k = clk_src.ref_50m;
			3'h6: k = clk_src.free_125m;
			3'h7: k = clk_src.rec_125m;
			default: k = 1'h0;
		endcase
		case (c)
			3'h0: return col ? {1'h0, coln} : 2'h2;
			3'h1: return {1'h0, col ? programmable_activity_indicator : spd};
			3'h2: return {1'h0, wol};
			3'h3: return {1'h0, k};
			3'h4: return {1'h0, ptx};
			3'h5: return {1'h0, prx};
			3'h6: return 2'h0;
			default: return 2'h1;
		endcase
	endfunction

	// ==========================================================
	// register bus master
	task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge i_clock);
		ax.awaddr <= a;
		ax.wdata <= d;
		ax.wstrb <= s;
		ax.awvalid <= 1'h1;
		ax.wvalid <= 1'h1;
		ax.bready <= 1'h1;
		do begin
			@(posedge i_clock);
			n++;
			if (ax.awvalid && rsp.awready) ax.awvalid <= 1'h0;
			if (ax.wvalid && rsp.wready) ax.wvalid <= 1'h0;
		end while (!(ax.bready && rsp.bvalid) && n < 50);
		ax.bready <= 1'h0;
		tmo(n);
		chk({30'h0, rsp.bresp}, ok(a) ? 32'h0 : 32'h2);
		if (s[0] && a == `PHYMX_ADDR_IND_MUX) {m_src[0], m_ctrl[0]} = {d[6:4], d[2:0]};
		if (s[0] && a == `PHYMX_ADDR_COL_MUX) {m_src[1], m_ctrl[1]} = {d[6:4], d[2:0]};
		if (a == `PHYMX_ADDR_FIBER)
			m_fib = {s[1] ? d[15:8] : m_fib[15:8], s[0] ? d[7:0] : m_fib[7:0]};
	endtask

	task automatic rchk(input logic [15:0] a);
		int n;
		n = 0;
		@(posedge i_clock);
		ax.araddr <= a;
		ax.arvalid <= 1'h1;
		ax.rready <= 1'h1;
		do begin
			@(posedge i_clock);
			n++;
			if (ax.arvalid && rsp.arready) ax.arvalid <= 1'h0;
		end while (!(ax.rready && rsp.rvalid) && n < 50);
		ax.rready <= 1'h0;
		tmo(n);
		chk(rsp.rdata, rexp(a));
		chk({30'h0, rsp.rresp}, ok(a) ? 32'h0 : 32'h2);
	endtask

	// ==========================================================
	// reset with fresh straps, pins under random sources
	task automatic rst(input logic en);
		logic [17:0] t;
		t = 18'($random(seed));
		t[0] = en;
		@(posedge i_clock);
		i_rst_n <= 1'h0;
		strap <= t;
		repeat (8) @(posedge i_clock);
		i_rst_n <= 1'h1;
		{m_ctrl[0], m_src[0], m_ctrl[1], m_src[1], m_fib} = {t[3:1], 9'h0, 16'hff00};
		repeat (2) @(posedge i_clock);
	endtask

	task automatic pinchk;
		logic [1:0] e;
		repeat (4) begin
			@(posedge i_clock);
			{spd, programmable_activity_indicator, coln, wol, ptx, prx} <= 6'($random(seed));
			mac_mode <= 2'($unsigned($random(seed)) % 3);
			@(negedge i_clock);
			e = pexp(m_ctrl[0], m_src[0], 1'b0);
			chk({31'h0, p1_oe_n}, {31'h0, e[1]});
			if (!e[1]) chk({31'h0, p1}, {31'h0, e[0]});
			e = pexp(m_ctrl[1], m_src[1], 1'b1);
			chk({31'h0, pc_oe_n}, {31'h0, e[1]});
			if (!e[1]) chk({31'h0, pc}, {31'h0, e[0]});
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		seed = 96636;
		bad_count = 0;
		samples_checked = 0;
		ax = '0;
		strap = '0;
		i_rst_n = 1'h0;
		{sd_level, fib, spd, programmable_activity_indicator, coln, wol, ptx, prx, mac_mode} = '0;
		rst(1'h0);
		foreach (m_src[i]) rchk(i ? `PHYMX_ADDR_COL_MUX : `PHYMX_ADDR_IND_MUX);
		rchk(`PHYMX_ADDR_FIBER);
		rchk(`PHYMX_ADDR_STRAP);
		rchk(16'h1190);
		axw(`PHYMX_ADDR_STRAP, 32'hffff, 4'hf);
		rchk(`PHYMX_ADDR_STRAP);
		axw(16'h1190, 32'h1, 4'hf);
		axw(`PHYMX_ADDR_IND_MUX, 32'h77, 4'h2);
		rchk(`PHYMX_ADDR_IND_MUX);
		for (int k = 0; k < 2; k++)
			for (int c = 0; c < 8; c++)
				for (int s = 0; s < 8; s++) begin
					axw(k ? `PHYMX_ADDR_COL_MUX : `PHYMX_ADDR_IND_MUX, {25'h0, 3'(s), 1'h0, 3'(c)}, 4'h1);
					pinchk();
					rchk(k ? `PHYMX_ADDR_COL_MUX : `PHYMX_ADDR_IND_MUX);
				end
		rst(1'h1);
		@(posedge i_clock);
		fib <= 1'h1;
		for (int p = 0; p < 2; p++)
			for (int l = 0; l < 2; l++) begin
				axw(`PHYMX_ADDR_FIBER, {16'h0, 15'h7f80, 1'(p)}, 4'h3);
				@(posedge i_clock);
				sd_level <= 1'(l);
				repeat (6) @(posedge i_clock);
				@(negedge i_clock);
				chk({31'h0, drop}, {31'h0, l == p});
				chk({31'h0, p1_oe_n}, 32'h1);
			end
		rchk(`PHYMX_ADDR_FIBER);
		@(posedge i_clock);
		fib <= 1'h0;
		repeat (4) @(posedge i_clock);
		@(negedge i_clock);
		chk({31'h0, drop}, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
